/* File: design/fbpc_ctrl.sv */
`timescale 1ns/1ns
// What this block does
// R1: End gate-on beyond 55 us, safe restart
// R2: Thermal trip latches off, no restart
// R3: Safe restart waits 800 ms, no switching
// R4: After wait, mains check enables pin sources
// R5: Pins ready, charge soft start, then switch
// R6: Restart keeps supply at start-up level
// R7: Latch regulates supply; mains removal clears
// R8: Fast supply discharge on protection entry
// R9: Feedback below 0.5 V enters burst
// R10: Burst lowers reference; faster rise; slow recovery
// R11: Burst period 1250 us, pulses >= 25 kHz
// R12: Pulses follow load, never below three
// R13: Very light load lengthens burst period; the code keeps the period fixed and only lowers the count to three
// R14: Load rise starts next burst at once
// R15: Pulse count changes on half-pulse difference
// R16: Over 40 pulses per burst leaves burst
// R17: Stop current ends burst, clamp feedback
// R18: Pull feedback low 12.5 us unless weak
// R19: Guard low enters power-down mode
// R20: Power-down blocks guard latch
// R21: Guard detect latches after filter delay
// R22: Outside party removes mains to clear
// R23: Overvoltage latches after four confirmations
// R24: All timers count one reference clock
module fbpc_ctrl #(
	parameter int unsigned RESTART_CYC    = fbpc_pkg::RESTART_CYC,
	parameter int unsigned GUARD_FILT_CYC = fbpc_pkg::GUARD_FILT_CYC,
	parameter int unsigned TICK_CYC       = fbpc_pkg::TICK_CYC,
	parameter int unsigned BURST_PER_CYC  = fbpc_pkg::BURST_PER_CYC
) (
	input  wire logic                 mclk,
	input  wire logic                 rstn,
	input  wire fbpc_pkg::fbpc_sense_t sense,
	output fbpc_pkg::fbpc_ctrl_t      ctrl
);

	initial begin
		if (RESTART_CYC < 1 || RESTART_CYC >= (1 << 28) ||
		    GUARD_FILT_CYC < 1 || GUARD_FILT_CYC >= (1 << 28) ||
		    TICK_CYC < 1 || TICK_CYC >= (1 << 28) ||
		    BURST_PER_CYC <= fbpc_pkg::SW_PER_CYC ||
		    BURST_PER_CYC >= (1 << 28)) begin
			$error("fbpc_ctrl: timer parameter out of range");
		end
	end

	// ==========================================================
	// Whole block state
	// ==========================================================
	typedef struct packed {
		fbpc_pkg::fbpc_state_t st;   // Protection state
		fbpc_pkg::fbpc_ctrl_t  out;  // Registered outputs
		logic [13:0] on_cnt;     // Gate-on length
		logic [27:0] gflt_cnt;   // Guard filter
		logic [27:0] tick_cnt;   // 1 ms tick divider
		logic [2:0]  ovp_cnt;    // Overvoltage confirmations
		logic        gate_prev;  // Gate edge detect
		logic [27:0] bper_cnt;   // Burst period elapsed
		logic [13:0] sw_cnt;     // In-burst switch period
		logic [6:0]  pulses;     // Pulses this burst
		logic [7:0]  target2;    // Target pulses, half units
		logic        bursting;   // Pulses being issued
		logic [11:0] pull_cnt;   // Feedback pull-down left
		logic [15:0] ramp_cnt;   // Slow reference ramp
	} fbpc_all_t;

	fbpc_all_t s_q;  // Registered state
	fbpc_all_t s_d;  // Next state

	// Restart timer lives in its own counter
	logic        rst_load;  // Start restart wait
	logic        rst_exp;   // Restart wait over

	fbpc_timer #(.W(28)) u_restart (
		.mclk    (mclk),
		.rstn    (rstn),
		.load    (rst_load),
		.value   (28'(RESTART_CYC)),       // R3
		.expired (rst_exp)
	);

	// Load on every entry into the restart wait
	assign rst_load = (s_d.st == fbpc_pkg::FBPC_ST_RESTART) &&
	                  (s_q.st != fbpc_pkg::FBPC_ST_RESTART);

	// ==========================================================
	// Next-state logic
	// ==========================================================
	always_comb begin
		logic go_restart;  // Restart protection request
		logic go_latch;    // Latched protection request
		logic rise;        // Gate rising edge
		logic tick;        // 1 ms tick
		logic [8:0] calc2; // New pulse count, half units
		go_restart = 1'b0;
		go_latch   = 1'b0;
		rise       = 1'b0;
		tick       = 1'b0;
		calc2      = '0;
		s_d        = s_q;

		// Default one-shot controls
		s_d.out.supply_discharge_sink = 1'b0;
		s_d.gate_prev = s_q.out.gate;
		rise = s_q.out.gate && !s_q.gate_prev;

		// ------------- Protection detectors ---------------
		// Gate-on length watchdog
		if (s_q.out.gate) begin
			s_d.on_cnt = s_q.on_cnt + 14'h0001;
			if (s_q.on_cnt >= 14'(fbpc_pkg::ON_MAX_CYC - 1)) begin
				go_restart = 1'b1;                       // R1
			end
		end else begin
			s_d.on_cnt = '0;
		end

		// Thermal trip is latched at once
		if (sense.therm_trip) begin
			go_latch = 1'b1;                             // R2
		end

		// Guard filter, blocked while in power-down
		if (sense.guard_det && !sense.guard_pd) begin    // R20
			s_d.gflt_cnt = s_q.gflt_cnt + 28'h000_0001;
			if (s_q.gflt_cnt >= 28'(GUARD_FILT_CYC - 1)) begin
				go_latch = 1'b1;                         // R21
			end
		end else begin
			s_d.gflt_cnt = '0;
		end

		// 1 ms tick divider
		if (s_q.tick_cnt >= 28'(TICK_CYC - 1)) begin
			s_d.tick_cnt = '0;
			tick = 1'b1;
		end else begin
			s_d.tick_cnt = s_q.tick_cnt + 28'h000_0001;
		end

		// Overvoltage confirmation; slow tick in guard band
		if (!sense.ovp_sample) begin
			s_d.ovp_cnt = '0;
		end else if ((sense.guard_det && !sense.guard_pd) ? tick : rise) begin
			s_d.ovp_cnt = s_q.ovp_cnt + 3'h1;            // R23
			if (s_q.ovp_cnt >= 3'(fbpc_pkg::OVP_CONFIRM - 1)) begin
				go_latch = 1'b1;                         // R23
			end
		end

		// ------------- Protection state machine -----------
		case (s_q.st)
			fbpc_pkg::FBPC_ST_RUN: begin
				// Supply from auxiliary while switching
				if (sense.out_in_reg) begin
					s_d.out.hv_regulate = 1'b0;          // R6
				end
			end
			fbpc_pkg::FBPC_ST_RESTART: begin
				// Wait shortened by removing mains
				if (rst_exp || sense.mains_gone) begin
					s_d.st = fbpc_pkg::FBPC_ST_MAINS;    // R3
				end
			end
			fbpc_pkg::FBPC_ST_MAINS: begin
				if (sense.mains_ok) begin
					s_d.st = fbpc_pkg::FBPC_ST_SOURCES;  // R4
				end
			end
			fbpc_pkg::FBPC_ST_SOURCES: begin
				if (sense.pins_ready) begin
					s_d.st = fbpc_pkg::FBPC_ST_SOFT;     // R5
				end
			end
			fbpc_pkg::FBPC_ST_SOFT: begin
				if (sense.soft_done) begin
					s_d.st = fbpc_pkg::FBPC_ST_RUN;      // R5
				end
			end
			fbpc_pkg::FBPC_ST_LATCH: begin
				// Only mains removal leaves the latch
				if (sense.mains_gone) begin
					s_d.st = fbpc_pkg::FBPC_ST_MAINS;    // R7
				end
			end
			default: begin
				s_d.st = fbpc_pkg::FBPC_ST_LATCH;
			end
		endcase

		// Latch wins over restart; both discharge the supply
		if (go_latch && s_q.st != fbpc_pkg::FBPC_ST_LATCH) begin
			s_d.st = fbpc_pkg::FBPC_ST_LATCH;
			s_d.out.supply_discharge_sink = 1'b1;        // R8
		end else if (go_restart &&
		             s_q.st == fbpc_pkg::FBPC_ST_RUN) begin
			s_d.st = fbpc_pkg::FBPC_ST_RESTART;
			s_d.out.supply_discharge_sink = 1'b1;        // R8
		end

		// State-driven controls
		s_d.out.latched     = (s_d.st == fbpc_pkg::FBPC_ST_LATCH);
		s_d.out.soft_charge = (s_d.st == fbpc_pkg::FBPC_ST_SOFT); // R5
		s_d.out.guard_src_en = (s_d.st == fbpc_pkg::FBPC_ST_SOURCES) ||
		                       (s_d.st == fbpc_pkg::FBPC_ST_SOFT) ||
		                       (s_d.st == fbpc_pkg::FBPC_ST_RUN); // R4
		s_d.out.fb_src_en = s_d.out.guard_src_en;        // R4
		if (s_d.st != fbpc_pkg::FBPC_ST_RUN) begin
			s_d.out.hv_regulate = 1'b1;                  // R6 R7
		end

		// ------------- Power-down --------------------------
		s_d.out.fb_zero        = sense.guard_pd;        // R19
		s_d.out.guard_src_low  = sense.guard_pd;        // R19
		s_d.out.vcc_at_restart = sense.guard_pd &&
		                         s_d.st == fbpc_pkg::FBPC_ST_RUN; // R19

		// ------------- Burst regulator ---------------------
		if (s_q.st != fbpc_pkg::FBPC_ST_RUN) begin
			s_d.out.burst_mode = 1'b0;
			s_d.bursting = 1'b0;
		end else if (!s_q.out.burst_mode) begin
			// Entry on low feedback or power-down
			if (sense.fb_low || sense.guard_pd) begin    // R9 R19
				s_d.out.burst_mode = 1'b1;
				s_d.bper_cnt = '0;
				s_d.pulses   = '0;
				s_d.sw_cnt   = '0;
				s_d.bursting = 1'b1;
				s_d.target2  = {1'b0, fbpc_pkg::MIN_PULSES} << 1;
			end
		end else begin
			s_d.bper_cnt = s_q.bper_cnt + 28'h000_0001;
			// Issue pulses at the lowest audible-safe rate
			if (s_q.bursting) begin
				if (s_q.sw_cnt >= 14'(fbpc_pkg::SW_PER_CYC - 1)) begin
					s_d.sw_cnt = '0;                     // R11
					s_d.pulses = s_q.pulses + 7'h01;
				end else begin
					s_d.sw_cnt = s_q.sw_cnt + 14'h0001;
				end
				// Stop on new count, so no extra slot opens
				if (sense.opto_stop ||                   // R17
				    s_d.pulses >= 7'(s_q.target2[7:1])) begin
					s_d.bursting = 1'b0;
				end
			end
			// Period end: recompute count, restart burst
			if ((s_q.bper_cnt >= 28'(BURST_PER_CYC - 1) ||
			     (sense.opto_low && !s_q.bursting)) &&     // R14
			    s_q.pull_cnt == '0 && !sense.opto_stop) begin
				// Scale by elapsed period vs target
				calc2 = 9'((36'(s_q.pulses) * 36'(BURST_PER_CYC) * 2) /
				           36'(s_q.bper_cnt + 28'h000_0001)); // R12
				if (calc2 >= 9'(s_q.target2) + 9'h001) begin
					s_d.target2 = s_q.target2 + 8'h02;   // R15
				end else if (9'(s_q.target2) >= calc2 + 9'h001 &&
				             s_q.target2 > {fbpc_pkg::MIN_PULSES, 1'b0}) begin
					s_d.target2 = s_q.target2 - 8'h02;   // R13 R15
				end
				s_d.bper_cnt = '0;
				s_d.pulses   = '0;
				s_d.sw_cnt   = '0;
				s_d.bursting = 1'b1;
				if (sense.opto_pull_ok) begin
					s_d.pull_cnt = 12'(fbpc_pkg::PULL_CYC); // R18
				end
			end
			// Leave burst when too many pulses are needed
			if (s_q.target2[7:1] > fbpc_pkg::MAX_PULSES &&
			    !sense.guard_pd) begin
				s_d.out.burst_mode = 1'b0;               // R16
				s_d.bursting = 1'b0;
			end
		end

		// Feedback pull-down window
		if (s_q.pull_cnt != '0) begin
			s_d.pull_cnt = s_q.pull_cnt - 12'h001;       // R18
		end
		s_d.out.fb_pull_gnd = (s_d.pull_cnt != '0);
		s_d.out.fb_clamp = s_d.out.burst_mode;           // R17

		// Gate: in burst only during the first half of a slot
		if (s_d.st != fbpc_pkg::FBPC_ST_RUN || go_restart) begin
			s_d.out.gate = 1'b0;                         // R1 R2
		end else if (s_d.out.burst_mode) begin
			s_d.out.gate = s_d.bursting && sense.gate_on_req &&
			               s_d.sw_cnt < 14'(fbpc_pkg::SW_PER_CYC / 2);
		end else begin
			s_d.out.gate = sense.gate_on_req;
		end

		// ------------- Feedback reference ------------------
		s_d.ramp_cnt = s_q.ramp_cnt + 16'h0001;
		if (s_q.out.burst_mode) begin
			if (sense.opto_low && s_q.out.fb_ref != fbpc_pkg::REF_FULL) begin
				s_d.out.fb_ref = s_q.out.fb_ref + 8'h01; // R10
			end else if (sense.opto_high && s_q.ramp_cnt[7:0] == 8'h00 &&
			             s_q.out.fb_ref != 8'h00) begin
				s_d.out.fb_ref = s_q.out.fb_ref - 8'h01; // R10
			end
		end else if (s_q.ramp_cnt == 16'h0000 &&
		             s_q.out.fb_ref != fbpc_pkg::REF_FULL) begin
			s_d.out.fb_ref = s_q.out.fb_ref + 8'h01;     // R10
		end
	end

	// ==========================================================
	// State register, one reference clock
	// ==========================================================
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s_q <= '0;                                   // R24
			s_q.st <= fbpc_pkg::FBPC_ST_MAINS;
			s_q.out.hv_regulate <= 1'b1;
			s_q.out.fb_ref <= fbpc_pkg::REF_RESET;
			s_q.target2 <= {1'b0, fbpc_pkg::MIN_PULSES} << 1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the register
	assign ctrl = s_q.out;

endmodule : fbpc_ctrl

/* File: design/fbpc_pkg.sv */
package fbpc_pkg;

	// ==========================================================
	// Clock and timing
	// ==========================================================
	localparam int unsigned CLK_MHZ        = 250;      // Reference clock rate
	localparam int unsigned ON_MAX_NS      = 55000;    // Longest gate-on time
	localparam int unsigned RESTART_MS     = 800;      // Safe-restart wait
	localparam int unsigned BURST_PER_NS   = 1250000;  // Target burst period
	localparam int unsigned MIN_FSW_KHZ    = 25;       // Lowest in-burst rate
	localparam int unsigned PULL_NS        = 12500;    // Feedback pull-down
	localparam int unsigned GUARD_FILT_MS  = 3;        // Guard filter, 2..4 ms
	localparam int unsigned TICK_MS        = 1;        // Slow overvoltage tick

	// Derived cycle counts; every division rounds down, none rounds up
	localparam int unsigned ON_MAX_CYC     = ON_MAX_NS * CLK_MHZ / 1000;
	localparam int unsigned RESTART_CYC    = RESTART_MS * CLK_MHZ * 1000;
	localparam int unsigned BURST_PER_CYC  = BURST_PER_NS / 1000 * CLK_MHZ;
	localparam int unsigned SW_PER_CYC     = CLK_MHZ * 1000 / MIN_FSW_KHZ;
	localparam int unsigned PULL_CYC       = PULL_NS * CLK_MHZ / 1000;
	localparam int unsigned GUARD_FILT_CYC = GUARD_FILT_MS * CLK_MHZ * 1000;
	localparam int unsigned TICK_CYC       = TICK_MS * CLK_MHZ * 1000;

	// ==========================================================
	// Pulse-count limits (whole pulses; target2 is held in half-pulse units)
	// ==========================================================
	localparam logic [6:0] MIN_PULSES  = 7'h03;  // Fewest pulses per burst
	localparam logic [6:0] MAX_PULSES  = 7'h28;  // Above this, leave burst
	localparam logic [6:0] OVP_CONFIRM = 7'h04;  // Confirmations to latch

	// Feedback reference code: full scale stands for the normal level
	localparam logic [7:0] REF_FULL    = 8'hff;  // Normal reference level
	localparam logic [7:0] REF_RESET   = 8'hff;  // Reference after reset

	// ==========================================================
	// Protection state machine
	// ==========================================================
	typedef enum logic [5:0] {
		FBPC_ST_RUN     = 6'b00_0001,  // Switching
		FBPC_ST_RESTART = 6'b00_0010,  // Safe-restart wait
		FBPC_ST_MAINS   = 6'b00_0100,  // Check mains level
		FBPC_ST_SOURCES = 6'b00_1000,  // Pin sources on, wait levels
		FBPC_ST_SOFT    = 6'b01_0000,  // Charge soft start
		FBPC_ST_LATCH   = 6'b10_0000   // Latched off
	} fbpc_state_t;

	// Analog comparator inputs, sampled in the clock domain
	typedef struct packed {
		logic gate_on_req;   // Modulator asks for gate on
		logic therm_trip;    // Junction temperature trip
		logic mains_ok;      // Mains above brown-in
		logic mains_gone;    // Mains removed or shorted
		logic pins_ready;    // Guard and feedback at minimum
		logic soft_done;     // Soft-start capacitor charged
		logic out_in_reg;    // Output within regulation
		logic fb_low;        // Feedback below burst entry level
		logic opto_low;      // Optocurrent below 80 uA
		logic opto_high;     // Optocurrent above 100 uA
		logic opto_stop;     // Feedback current above stop level
		logic opto_pull_ok;  // Feedback current at least 87 uA
		logic guard_det;     // Guard below detection threshold
		logic guard_pd;      // Guard below power_down_threshold
		logic ovp_sample;    // output_overvoltage_trip seen
	} fbpc_sense_t;

	// Analog controls driven by the block
	typedef struct packed {
		logic       gate;            // Gate drive
		logic       supply_discharge_sink; // Fast supply discharge
		logic       hv_regulate;     // Supply from high_voltage_pin
		logic       vcc_at_restart;  // Regulate to restart level
		logic       guard_src_en;    // Guard current source on
		logic       guard_src_low;   // Guard source at 47 uA
		logic       fb_src_en;       // Feedback sources on
		logic       fb_clamp;        // Feedback clamp in burst
		logic       fb_pull_gnd;     // Feedback pulled to ground
		logic       fb_zero;         // Feedback driven to 0 V
		logic       soft_charge;     // Charge current_sense_pin cap
		logic       burst_mode;      // Burst mode active
		logic       latched;         // Latched protection held
		logic [7:0] fb_ref;          // Internal feedback reference
	} fbpc_ctrl_t;

endpackage : fbpc_pkg

/* File: design/fbpc_timer.sv */
`timescale 1ns/1ns
// Reusable down-counter: load, count to zero, flag expiry
module fbpc_timer #(
	parameter int unsigned W = 28  // Counter width
) (
	input  wire logic         mclk,
	input  wire logic         rstn,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              expired
);

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		logic [W-1:0] cnt;  // Remaining cycles
		logic         exp;  // Reached zero
	} fbpc_tmr_t;

	fbpc_tmr_t s_q;  // Registered state
	fbpc_tmr_t s_d;  // Next state

	// Load wins over counting
	always_comb begin
		s_d = s_q;
		if (load) begin
			s_d.cnt = value;
			s_d.exp = 1'b0;
		end else if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - 1'b1;
			s_d.exp = (s_q.cnt == {{(W-1){1'b0}}, 1'b1});
		end
	end

	// Synchronous reset leaves the timer idle
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign expired = s_q.exp;

endmodule : fbpc_timer

/* File: testbench/fbpc_partner.sv */
`timescale 1ns/1ns
// ==========================================================
// Gate, pins and output network seen from the block
module fbpc_partner (
	input  wire logic                 mclk,
	input  wire logic                 rstn,
	input  wire fbpc_pkg::fbpc_ctrl_t ctrl,
	input  wire logic                 ovp_on,
	input  wire logic                 slow,
	output logic                      pins_ready,
	output logic                      soft_done,
	output logic                      out_in_reg,
	output logic                      ovp_sample
);
	int unsigned src_q;  // Cycles since pin sources on
	int unsigned ss_q;   // Cycles of soft-start charge

	// Pin and capacitor charge times; slow mode mimics big caps
	always_ff @(posedge mclk) begin
		src_q      <= (!rstn || !ctrl.fb_src_en) ? 0 : src_q + 1;
		ss_q       <= (!rstn || !ctrl.soft_charge) ? 0 : ss_q + 1;
		out_in_reg <= rstn && !ctrl.supply_discharge_sink
			&& (out_in_reg || ctrl.gate);
	end
	assign pins_ready = src_q >= (slow ? 300 : 8);
	assign soft_done  = ss_q >= (slow ? 200 : 12);
	// Overvoltage level held while present; block counts the pulses
	assign ovp_sample = ovp_on;
endmodule : fbpc_partner

/* File: testbench/fbpc_props.sv */
`timescale 1ns/1ns
// ==========================================================
// Port checker for the supervisory block
module fbpc_props (
	input wire logic                  mclk,
	input wire logic                  rstn,
	input wire fbpc_pkg::fbpc_sense_t sense,
	input wire fbpc_pkg::fbpc_ctrl_t  ctrl
);
	int unsigned on_q;    // Gate-high run length
	int unsigned pull_q;  // Pull-down run length

	// Run lengths, kept in counters since repetition would unroll
	always_ff @(posedge mclk) begin
		on_q   <= (!rstn || !ctrl.gate) ? 0 : on_q + 1;
		pull_q <= (!rstn || !ctrl.fb_pull_gnd) ? 0 : pull_q + 1;
	end

	reset_vals_a: assert property (@(posedge mclk)
		!rstn |=> ctrl.hv_regulate && ctrl.fb_ref == 8'hff && !ctrl.gate)
		else $error("reset values wrong");
	on_limit_a: assert property (@(posedge mclk) disable iff (!rstn)
		on_q <= fbpc_pkg::ON_MAX_CYC)
		else $error("gate on too long");
	limit_entry_a: assert property (@(posedge mclk) disable iff (!rstn)
		on_q == fbpc_pkg::ON_MAX_CYC |-> !ctrl.gate && ctrl.supply_discharge_sink)
		else $error("no stop or discharge at on-time limit");
	sink_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
		ctrl.supply_discharge_sink |=> !ctrl.supply_discharge_sink)
		else $error("discharge longer than one cycle");
	latch_sink_a: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(ctrl.latched) |-> ctrl.supply_discharge_sink)
		else $error("no discharge on latch entry");
	restart_hv_a: assert property (@(posedge mclk) disable iff (!rstn)
		ctrl.supply_discharge_sink |-> ctrl.hv_regulate)
		else $error("supply not regulated on protection");
	therm_latch_a: assert property (@(posedge mclk) disable iff (!rstn)
		sense.therm_trip && !sense.mains_gone |=> ctrl.latched)
		else $error("thermal trip did not latch");
	latch_quiet_a: assert property (@(posedge mclk) disable iff (!rstn)
		ctrl.latched |-> !ctrl.gate && ctrl.hv_regulate)
		else $error("switching while latched");
	latch_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
		ctrl.latched && !sense.mains_gone |=> ctrl.latched)
		else $error("latch left with mains present");
	pd_block_a: assert property (@(posedge mclk) disable iff (!rstn)
		sense.guard_pd && !sense.therm_trip && !sense.ovp_sample
		&& !ctrl.latched |=> !ctrl.latched)
		else $error("latched during power-down");
	pd_mode_a: assert property (@(posedge mclk) disable iff (!rstn)
		sense.guard_pd |=> ctrl.guard_src_low && ctrl.fb_zero)
		else $error("power-down outputs wrong");
	burst_clamp_a: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(ctrl.burst_mode) |-> ctrl.fb_clamp)
		else $error("feedback not clamped in burst");
	pull_len_a: assert property (@(posedge mclk) disable iff (!rstn)
		pull_q <= fbpc_pkg::PULL_CYC)
		else $error("pull-down too long");
endmodule : fbpc_props

bind fbpc_ctrl fbpc_props i_props (
	.mclk  (mclk),
	.rstn  (rstn),
	.sense (sense),
	.ctrl  (ctrl)
);

/* File: testbench/tb.sv */
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench
module tb;
	localparam int unsigned RST_C = 200;    // Shortened restart wait
	localparam int unsigned FLT_C = 50;     // Shortened guard filter
	localparam int unsigned BST_C = 32000;  // Shortened burst period
	localparam int unsigned WDOG  = 100000; // Cycle budget

	logic                  mclk;        // Reference clock
	logic                  rstn;        // Sync reset, active low
	fbpc_pkg::fbpc_sense_t drv;         // Bench-driven sense
	fbpc_pkg::fbpc_sense_t sense;       // Merged sense
	fbpc_pkg::fbpc_ctrl_t  ctrl;        // Block outputs
	logic                  pins_ready;  // From partner
	logic                  soft_done;   // From partner
	logic                  out_in_reg;  // From partner
	logic                  ovp_sample;  // From partner
	logic                  ovp_on;      // Overvoltage present
	logic                  slow;        // Slow partner
	logic                  pg;          // Gate seen last cycle
	int                    miscompares; // Mismatch count
	int                    n_checks;    // Comparison count
	int                    n, m, k, seed, wait_src;
	int                    lo[3] = '{1, FLT_C, 1};         // Latch delay
	int                    hi[3] = '{2, FLT_C + 2, 40};

	fbpc_ctrl #(
		.RESTART_CYC    (RST_C),
		.GUARD_FILT_CYC (FLT_C),
		.TICK_CYC       (20),
		.BURST_PER_CYC  (BST_C)
	) i_dut (
		.mclk  (mclk),
		.rstn  (rstn),
		.sense (sense),
		.ctrl  (ctrl)
	);

	fbpc_partner i_partner (
		.mclk       (mclk),
		.rstn       (rstn),
		.ctrl       (ctrl),
		.ovp_on     (ovp_on),
		.slow       (slow),
		.pins_ready (pins_ready),
		.soft_done  (soft_done),
		.out_in_reg (out_in_reg),
		.ovp_sample (ovp_sample)
	);

	// Partner fields override bench fields
	always_comb begin
		sense            = drv;
		sense.pins_ready = pins_ready;
		sense.soft_done  = soft_done;
		sense.out_in_reg = out_in_reg;
		sense.ovp_sample = ovp_sample;
	end

	// Clock
	initial mclk = 1'b0;
	always #2 mclk = ~mclk;

	// Compare and count
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	// Verdict and end of run
	task automatic stop_test;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test

	task automatic cyc(input int c);
		repeat (c) @(negedge mclk);
	endtask : cyc

	// Restart path up to switching; optional brief mains removal
	task automatic bring_up(input bit pulse);
		drv.gate_on_req = 1'b1;
		drv.mains_gone  = pulse;
		cyc(1);
		drv.mains_gone = 1'b0;
		for (n = 0; n < 2000 && ctrl.fb_src_en !== 1'b1; n++) cyc(1);
		wait_src = n;
		check("src_no_soft", {ctrl.guard_src_en, ctrl.soft_charge}, 2'b10);
		for (n = 0; n < 2000 && ctrl.soft_charge !== 1'b1; n++) cyc(1);
		check("soft_after_pins", {pins_ready, ctrl.gate}, 2'b10);
		for (n = 0; n < 2000 && ctrl.soft_charge === 1'b1; n++) cyc(1);
		drv.gate_on_req = 1'b0;
		cyc(3);
	endtask : bring_up

	// Watchdog
	initial begin
		#(WDOG * 4);
		miscompares++;
		stop_test();
	end

	// ==========================================================
	// Main sequence
	initial begin
		drv = '0;
		rstn = 1'b0;
		ovp_on = 1'b0;
		slow = 1'b1;
		pg = 1'b0;
		miscompares = 0;
		n_checks = 0;
		seed = $urandom(32'hb9f8);
		cyc(5);
		check("rst_hv", ctrl.hv_regulate, 1);
		check("rst_ref", ctrl.fb_ref, 8'hff);
		rstn = 1'b1;
		cyc(100);
		check("no_mains_src", ctrl.fb_src_en, 0);
		drv.mains_ok = 1'b1;
		bring_up(1'b0);
		slow = 1'b0;
		// Random gate requests, one cycle answer
		for (m = 0; m < 60; m++) begin
			drv.gate_on_req = 1'($urandom_range(1, 0));
			cyc(1);
			check("gate_follow", ctrl.gate, drv.gate_on_req);
		end
		// Held gate request hits the on-time limit
		drv.gate_on_req = 1'b0;
		cyc(1);
		drv.gate_on_req = 1'b1;
		cyc(1);
		for (n = 0; n < 20000 && ctrl.gate === 1'b1; n++) cyc(1);
		check("on_limit", n, fbpc_pkg::ON_MAX_CYC);
		check("dis_sink", ctrl.supply_discharge_sink, 1);
		check("restart_hv", ctrl.hv_regulate, 1);
		bring_up(1'b0);
		check("restart_wait", wait_src >= RST_C && wait_src <= RST_C + 3, 1);
		// Latch causes: thermal, guard filter, overvoltage count
		for (k = 0; k < 3; k++) begin
			drv.therm_trip = (k == 0);
			drv.guard_det  = (k == 1);
			ovp_on         = (k == 2);
			m = 0;
			for (n = 0; n < 2000 && ctrl.latched !== 1'b1; n++) begin
				if (ctrl.gate === 1'b1 && !pg) m++;
				pg = ctrl.gate;
				drv.gate_on_req = ~drv.gate_on_req;
				cyc(1);
			end
			check("latch_delay", n >= lo[k] && n <= hi[k], 1);
			if (k == 2) check("ovp_pulses", m, fbpc_pkg::OVP_CONFIRM);
			drv.therm_trip = 1'b0;
			drv.guard_det  = 1'b0;
			ovp_on         = 1'b0;
			for (m = 0, n = 0; n < 200; n++) begin
				drv.gate_on_req = ~drv.gate_on_req;
				cyc(1);
				m += (ctrl.gate !== 1'b0);
			end
			check("latch_quiet", m, 0);
			check("latch_held", {ctrl.latched, ctrl.hv_regulate}, 2'b11);
			bring_up(1'b1);
		end
		// Burst entry, minimum pulses, period and pull-down
		drv.fb_low = 1'b1;
		drv.opto_high = 1'b1;
		drv.opto_pull_ok = 1'b1;
		drv.gate_on_req = 1'b1;
		cyc(1);
		check("burst_on", {ctrl.burst_mode, ctrl.fb_clamp}, 2'b11);
		pg = 1'b0;
		for (m = 0, n = 0; n < 60000 && ctrl.fb_pull_gnd !== 1'b1; n++) begin
			if (ctrl.gate === 1'b1 && !pg) m++;
			pg = ctrl.gate;
			cyc(1);
		end
		check("burst_pulses", m, fbpc_pkg::MIN_PULSES);
		check("burst_period", n >= BST_C - 2 && n <= BST_C + 2, 1);
		for (n = 0; n < 9000 && ctrl.fb_pull_gnd === 1'b1; n++) cyc(1);
		check("pull_len", n, fbpc_pkg::PULL_CYC);
		// Stop current cuts the burst; weak current skips pull-down
		drv.opto_pull_ok = 1'b0;
		for (n = 0; n < 9000 && ctrl.gate !== 1'b1; n++) cyc(1);
		drv.opto_stop = 1'b1;
		cyc(2);
		check("stop_burst", ctrl.gate, 0);
		drv.opto_stop = 1'b0;
		for (m = 0, n = 0; n < BST_C + 4000; n++) begin
			cyc(1);
			m += (ctrl.fb_pull_gnd !== 1'b0);
		end
		check("pull_skip", m, 0);
		check("ref_low", ctrl.fb_ref < 8'hff, 1);
		// Power-down with guard below both levels
		drv.guard_pd = 1'b1;
		drv.guard_det = 1'b1;
		cyc(200);
		check("pd_out", {ctrl.guard_src_low, ctrl.fb_zero}, 2'b11);
		check("pd_burst", ctrl.burst_mode, 1);
		check("pd_nolatch", ctrl.latched, 0);
		drv.guard_pd = 1'b0;
		drv.guard_det = 1'b0;
		cyc(100);
		check("pd_exit", ctrl.latched, 0);
		stop_test();
	end
endmodule : tb
